// file: hw/ccu_pkg.sv
// capture/compare unit: register map, field positions, mode encodings
// assumes an 8-bit register port and a 16-bit companion timer on the same clock
package ccu_pkg;

  // ************************************************
  // register map (byte addresses on the plain port)
  // ************************************************
  localparam int CCU_AW = 3;
  localparam int CCU_DW = 8;
  localparam logic [2:0] CCU_CTRL_ADDR = 3'h0; // unit_control_reg
  localparam logic [2:0] CCU_MLO_ADDR = 3'h1; // match_value_low
  localparam logic [2:0] CCU_MHI_ADDR = 3'h2; // match_value_high
  localparam logic [2:0] CCU_IRQ_ADDR = 3'h3; // unit_irq_flag / unit_irq_enable
  localparam logic [2:0] CCU_CFG_ADDR = 3'h4; // adc source select, status

  // ************************************************
  // field positions and reset values
  // ************************************************
  localparam int CCU_EN_BIT = 7;
  localparam int CCU_OUT_BIT = 5;
  localparam int CCU_MODE_LSB = 0;
  localparam int CCU_FLAG_BIT = 0;
  localparam int CCU_IE_BIT = 1;
  localparam int CCU_ADCSEL_BIT = 0;
  localparam int CCU_HOLD_BIT = 1;
  localparam logic [7:0] CCU_REG_RST = 8'h00;
  localparam logic [15:0] CCU_MATCH_RST = 16'h0000;
  localparam logic [3:0] CCU_PRE_RST = 4'h0;

  // ************************************************
  // unit_mode_select encodings
  // ************************************************
  localparam logic [3:0] CCU_M_OFF = 4'h0;
  localparam logic [3:0] CCU_M_TOG_RST = 4'h1; // toggle, reset timer
  localparam logic [3:0] CCU_M_TOG = 4'h2;
  localparam logic [3:0] CCU_M_CAP_ANY = 4'h3; // every edge
  localparam logic [3:0] CCU_M_CAP_FALL = 4'h4;
  localparam logic [3:0] CCU_M_CAP_RISE = 4'h5;
  localparam logic [3:0] CCU_M_CAP_4 = 4'h6; // every 4th rising
  localparam logic [3:0] CCU_M_CAP_16 = 4'h7; // every 16th rising
  localparam logic [3:0] CCU_M_SET = 4'h8;
  localparam logic [3:0] CCU_M_CLR = 4'h9;
  localparam logic [3:0] CCU_M_SWI = 4'hA; // software interrupt, output latch untouched
  localparam logic [3:0] CCU_M_TRIG = 4'hB; // reset timer, output latch untouched; conversion only if adc source selected

  // prescaler terminal counts and count step
  localparam logic [3:0] CCU_PRE_LAST4 = 4'h3;
  localparam logic [3:0] CCU_PRE_LAST16 = 4'hF;
  localparam logic [3:0] CCU_PRE_ONE = 4'h1;

endpackage : ccu_pkg

// file: hw/ccu_top.sv
// capture/compare unit beside a companion 16-bit timer
// assumes timer count, sleep and timer clock source arrive on clk; unit pin is asynchronous
//
// The address map and the strobed register port are this design's own decisions.
`timescale 1ns/1ns

// Function
// - mode change may raise spurious flag
// - mode field selects capture prescaler
// - prescaler cleared when off, non-capture, reset
// - prescaler switch keeps count; clear control first
// - timer holds count in sleep unless externally clocked, resumes
// - capture works in sleep with external clock
// - compare match value against timer count
// - match toggles, sets, clears, triggers or interrupts
// - every match sets flag, may request conversion
// - clearing control forces output latch low
// - unit output also offered to peripherals
// - match with adc source selected issues conversion trigger
// - changed match value cancels timer reset
// - compare in sleep only if timer runs
module ccu_top
  import ccu_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register port
  input wire logic [CCU_AW-1:0] addr,
  input wire logic [CCU_DW-1:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [CCU_DW-1:0] rdata,
  // companion timer
  input wire logic [15:0] timer_count,
  input wire logic timer_ext_clk,
  output logic timer_reset,
  output logic timer_hold,
  // power state
  input wire logic sleep,
  output logic wake_req,
  // capture input and compare output
  input wire logic unit_pin_in,
  output logic unit_out,
  // system events
  output logic unit_irq_flag,
  output logic adc_trigger
);

  // ************************************************
  // mode decoding
  // ************************************************
  function automatic logic ccu_is_cap(input logic [3:0] m);
    ccu_is_cap = (m >= CCU_M_CAP_ANY) && (m <= CCU_M_CAP_16);
  endfunction : ccu_is_cap

  function automatic logic ccu_is_cmp(input logic [3:0] m);
    ccu_is_cmp = (m == CCU_M_TOG_RST) || (m == CCU_M_TOG) || ((m >= CCU_M_SET) && (m <= CCU_M_TRIG));
  endfunction : ccu_is_cmp

  // ************************************************
  // state
  // ************************************************
  logic [7:0] ctrl, next_ctrl;
  logic [15:0] match_val, next_match_val;
  logic irq_en, next_irq_en;
  logic adc_sel, next_adc_sel;
  logic [3:0] pre_cnt, next_pre_cnt;
  logic pin_s1, pin_s2, pin_s3;
  logic pin_level, next_pin_level;
  logic match_q, next_match_q;
  logic reset_pend, next_reset_pend;
  logic next_unit_out, next_flag, next_adc_trigger, next_timer_reset;
  logic next_wake_req, next_timer_hold;
  logic [CCU_DW-1:0] next_rdata;

  logic [3:0] mode;
  logic enabled;
  logic timer_runs;
  logic pin_rise, pin_fall;
  logic match_now, match_evt, cap_evt, edge_ok;

  assign mode = ctrl[CCU_MODE_LSB +: 4];
  assign enabled = ctrl[CCU_EN_BIT];
  // system clock stops in sleep; only an external timer clock keeps things moving
  assign timer_runs = !sleep || timer_ext_clk;

  // ************************************************
  // pin synchroniser: three flops, accept once 2nd and 3rd agree
  // ************************************************
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      pin_s1 <= 1'b0;
      pin_s2 <= 1'b0;
      pin_s3 <= 1'b0;
    end
    else
    begin
      pin_s1 <= unit_pin_in;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
    end
  end

  // ************************************************
  // next-state logic
  // ************************************************
  always_comb
  begin
    // pin edges from the agreed level
    next_pin_level = (pin_s2 == pin_s3) ? pin_s3 : pin_level;
    pin_rise = next_pin_level && !pin_level;
    pin_fall = !next_pin_level && pin_level;

    // capture edge qualification and prescaling
    cap_evt = 1'b0;
    next_pre_cnt = pre_cnt;
    case (mode)
      CCU_M_CAP_ANY: edge_ok = pin_rise || pin_fall;
      CCU_M_CAP_FALL: edge_ok = pin_fall;
      default: edge_ok = pin_rise;
    endcase
    if (!enabled || !ccu_is_cap(mode))
      next_pre_cnt = CCU_PRE_RST;
    else if (edge_ok && timer_runs)
    begin
      // a prescaler switch keeps the old count on purpose: one odd capture is possible
      case (mode)
        CCU_M_CAP_4:
        begin
          cap_evt = (pre_cnt >= CCU_PRE_LAST4);
          next_pre_cnt = cap_evt ? CCU_PRE_RST : pre_cnt + CCU_PRE_ONE;
        end
        CCU_M_CAP_16:
        begin
          cap_evt = (pre_cnt == CCU_PRE_LAST16);
          next_pre_cnt = cap_evt ? CCU_PRE_RST : pre_cnt + CCU_PRE_ONE;
        end
        default: cap_evt = 1'b1;
      endcase
    end

    // compare: one event per arrival of equality
    match_now = enabled && ccu_is_cmp(mode) && timer_runs && (timer_count == match_val);
    match_evt = match_now && !match_q;
    next_match_q = match_now;

    // software register writes
    next_ctrl = ctrl;
    next_match_val = match_val;
    next_irq_en = irq_en;
    next_adc_sel = adc_sel;
    next_flag = unit_irq_flag;
    next_unit_out = unit_out;
    if (wr)
    begin
      case (addr)
        CCU_CTRL_ADDR: next_ctrl = wdata & 8'h8F;
        CCU_MLO_ADDR: next_match_val[7:0] = wdata;
        CCU_MHI_ADDR: next_match_val[15:8] = wdata;
        CCU_IRQ_ADDR:
        begin
          next_flag = wdata[CCU_FLAG_BIT];
          next_irq_en = wdata[CCU_IE_BIT];
        end
        CCU_CFG_ADDR: next_adc_sel = wdata[CCU_ADCSEL_BIT];
        default: next_ctrl = ctrl;
      endcase
    end

    // capture copies the timer; hardware beats software on the same edge
    if (cap_evt)
    begin
      next_match_val = timer_count;
      next_flag = 1'b1;
    end

    // compare actions on the output latch
    if (match_evt)
    begin
      next_flag = 1'b1;
      case (mode)
        CCU_M_TOG_RST, CCU_M_TOG: next_unit_out = !unit_out;
        CCU_M_SET: next_unit_out = 1'b1;
        CCU_M_CLR: next_unit_out = 1'b0;
        default: next_unit_out = unit_out;
      endcase
    end

    // clearing control beats a match on the same edge, so the latch reads low afterwards
    if (wr && (addr == CCU_CTRL_ADDR) && (wdata == CCU_REG_RST))
      next_unit_out = 1'b0;

    // conversion trigger now, timer reset one edge later if still matching
    next_adc_trigger = match_evt && adc_sel;
    next_reset_pend = match_evt && ((mode == CCU_M_TOG_RST) || (mode == CCU_M_TRIG));
    next_timer_reset = reset_pend && match_now;

    // sleep side effects
    next_timer_hold = sleep && !timer_ext_clk;
    next_wake_req = sleep && irq_en && next_flag;

    // read path, data valid the cycle after the strobe
    next_rdata = CCU_REG_RST;
    if (rd)
    begin
      case (addr)
        CCU_CTRL_ADDR: next_rdata = ctrl | (8'(unit_out) << CCU_OUT_BIT);
        CCU_MLO_ADDR: next_rdata = match_val[7:0];
        CCU_MHI_ADDR: next_rdata = match_val[15:8];
        CCU_IRQ_ADDR: next_rdata = (8'(irq_en) << CCU_IE_BIT) | (8'(unit_irq_flag) << CCU_FLAG_BIT);
        CCU_CFG_ADDR: next_rdata = (8'(timer_hold) << CCU_HOLD_BIT) | (8'(adc_sel) << CCU_ADCSEL_BIT);
        default: next_rdata = CCU_REG_RST;
      endcase
    end
  end

  // ************************************************
  // registers
  // ************************************************
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl <= CCU_REG_RST;
      match_val <= CCU_MATCH_RST;
      irq_en <= 1'b0;
      adc_sel <= 1'b0;
      pre_cnt <= CCU_PRE_RST;
      pin_level <= 1'b0;
      match_q <= 1'b0;
      reset_pend <= 1'b0;
      unit_out <= 1'b0;
      unit_irq_flag <= 1'b0;
      adc_trigger <= 1'b0;
      timer_reset <= 1'b0;
      timer_hold <= 1'b0;
      wake_req <= 1'b0;
      rdata <= CCU_REG_RST;
    end
    else
    begin
      ctrl <= next_ctrl;
      match_val <= next_match_val;
      irq_en <= next_irq_en;
      adc_sel <= next_adc_sel;
      pre_cnt <= next_pre_cnt;
      pin_level <= next_pin_level;
      match_q <= next_match_q;
      reset_pend <= next_reset_pend;
      unit_out <= next_unit_out;
      unit_irq_flag <= next_flag;
      adc_trigger <= next_adc_trigger;
      timer_reset <= next_timer_reset;
      timer_hold <= next_timer_hold;
      wake_req <= next_wake_req;
      rdata <= next_rdata;
    end
  end

  // ************************************************
  // checks
  // ************************************************
  pre_clear_a: assert property (@(posedge clk) disable iff (!rstn)
    (!enabled || !ccu_is_cap(mode)) |=> (pre_cnt == CCU_PRE_RST))
    else $error("prescaler not cleared outside capture");

  pre_range_a: assert property (@(posedge clk) disable iff (!rstn)
    (enabled && mode == CCU_M_CAP_4) |-> (pre_cnt <= CCU_PRE_LAST4))
    else $error("divide-by-four prescaler overran");

  cap_copy_a: assert property (@(posedge clk) disable iff (!rstn)
    cap_evt |=> (match_val == $past(timer_count)) && unit_irq_flag)
    else $error("capture did not copy timer or set flag");

  match_flag_a: assert property (@(posedge clk) disable iff (!rstn)
    match_evt |=> unit_irq_flag)
    else $error("compare match left flag clear");

  toggle_out_a: assert property (@(posedge clk) disable iff (!rstn)
    (match_evt && (mode == CCU_M_TOG) && !wr) |=> (unit_out != $past(unit_out)))
    else $error("toggle mode did not toggle output");

  set_clr_a: assert property (@(posedge clk) disable iff (!rstn)
    (match_evt && !wr && (mode == CCU_M_SET || mode == CCU_M_CLR)) |=> (unit_out == (mode == CCU_M_SET)))
    else $error("set or clear action wrong");

  ctrl_clear_a: assert property (@(posedge clk) disable iff (!rstn)
    (wr && addr == CCU_CTRL_ADDR && wdata == CCU_REG_RST) |=> !unit_out ##1 !unit_out)
    else $error("clearing control left output high");

  adc_trig_a: assert property (@(posedge clk) disable iff (!rstn)
    (match_evt && adc_sel) |=> (adc_trigger && unit_irq_flag) ##1 !adc_trigger)
    else $error("conversion trigger missing or too long");

  reset_cancel_a: assert property (@(posedge clk) disable iff (!rstn)
    (reset_pend && !match_now) |=> !timer_reset)
    else $error("timer reset issued after match value moved");

  sleep_stop_a: assert property (@(posedge clk) disable iff (!rstn)
    (sleep && !timer_ext_clk) |-> !match_evt && !cap_evt)
    else $error("event while timer stopped in sleep");

  hold_a: assert property (@(posedge clk) disable iff (!rstn)
    (sleep && !timer_ext_clk) [*2] |-> timer_hold)
    else $error("timer hold not raised in sleep");

endmodule : ccu_top

// file: tb/capture_compare_unit_test.sv
// self-checking bench for the capture/compare unit
// assumes the timer model on the same clock; unit_out is taken as the routed pin
`timescale 1ns/1ns
module capture_compare_unit_test
  import ccu_pkg::*;
;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [CCU_AW-1:0] addr = '0;
  logic [CCU_DW-1:0] wdata = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [CCU_DW-1:0] rdata;
  logic [15:0] timer_count;
  logic timer_ext_clk = 1'b0;
  logic timer_reset;
  logic timer_hold;
  logic sleep = 1'b0;
  logic wake_req;
  logic unit_pin_in = 1'b0;
  logic unit_out;
  logic unit_irq_flag;
  logic adc_trigger;
  logic run = 1'b0;
  logic load = 1'b0;
  logic [15:0] load_val = '0;
  logic [31:0] seed = 32'h6307_16d6;
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n_adc = 0;
  int n_rst = 0;
  logic [3:0] cmp_modes [6] = '{CCU_M_SET, CCU_M_CLR, CCU_M_TOG, CCU_M_SWI, CCU_M_TOG_RST, CCU_M_TRIG};
  logic [3:0] cap_modes [5] = '{CCU_M_CAP_ANY, CCU_M_CAP_FALL, CCU_M_CAP_RISE, CCU_M_CAP_4, CCU_M_CAP_16};

  ccu_top ccu_top_i (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .timer_count(timer_count), .timer_ext_clk(timer_ext_clk), .timer_reset(timer_reset),
    .timer_hold(timer_hold), .sleep(sleep), .wake_req(wake_req), .unit_pin_in(unit_pin_in),
    .unit_out(unit_out), .unit_irq_flag(unit_irq_flag), .adc_trigger(adc_trigger));
  ccu_timer_model ccu_timer_model_i (.clk(clk), .rstn(rstn), .run(run), .load(load), .load_val(load_val),
    .timer_reset(timer_reset), .timer_hold(timer_hold), .timer_count(timer_count));

  // ************************************************
  // clock, pulse counters and hang guard
  // ************************************************
  always #25 clk = ~clk;

  // pulses are counted, not sampled, so their exact cycle cannot be missed
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    n_adc <= n_adc + adc_trigger;
    n_rst <= n_rst + timer_reset;
    if (cycles == 20000)
    begin
      errors++;
      finish_test();
    end
  end

  // ************************************************
  // helpers
  // ************************************************
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic int div_of(input logic [3:0] mo);
    return (mo == CCU_M_CAP_4) ? 4 : (mo == CCU_M_CAP_16) ? 16 : 1;
  endfunction : div_of

  // output level after one match, starting from a low latch
  function automatic logic out_of(input logic [3:0] mo);
    return (mo == CCU_M_SET) || (mo == CCU_M_TOG) || (mo == CCU_M_TOG_RST);
  endfunction : out_of

  function automatic logic rst_of(input logic [3:0] mo);
    return (mo == CCU_M_TOG_RST) || (mo == CCU_M_TRIG);
  endfunction : rst_of

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask : rd_reg

  task automatic load_timer(input logic [15:0] v);
    @(posedge clk);
    load <= 1'b1;
    load_val <= v;
    @(posedge clk);
    load <= 1'b0;
  endtask : load_timer

  // each level held well beyond the synchroniser depth
  task automatic pulse();
    @(posedge clk);
    unit_pin_in <= 1'b1;
    repeat (5) @(posedge clk);
    unit_pin_in <= 1'b0;
    repeat (6) @(posedge clk);
    #1;
  endtask : pulse

  task automatic finish_test();
    if (errors == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test

  // ************************************************
  // main sequence
  // ************************************************
  initial
  begin
    logic [7:0] lo;
    logic [7:0] hi;
    logic [15:0] m;
    logic [3:0] mo;
    int a0;
    int r0;
    repeat (4) @(posedge clk);
    rstn <= 1'b1;
    // reset values, unmapped place, read-only control bits
    wr_reg(3'h5, 8'hFF);
    for (int i = 0; i < 6; i++)
    begin
      rd_reg(i[2:0], lo);
      chk(16'(lo), 16'h0000);
    end
    wr_reg(CCU_CTRL_ADDR, 8'h7F);
    rd_reg(CCU_CTRL_ADDR, lo);
    chk(16'(lo), 16'h000F);
    wr_reg(CCU_CTRL_ADDR, 8'h00);
    // compare: every action, with conversion requests selected
    wr_reg(CCU_CFG_ADDR, 8'h01);
    foreach (cmp_modes[k])
    begin
      mo = cmp_modes[k];
      m = 16'(rnd()) | 16'h0001;
      load_timer(~m);
      wr_reg(CCU_MLO_ADDR, m[7:0]);
      wr_reg(CCU_MHI_ADDR, m[15:8]);
      wr_reg(CCU_CTRL_ADDR, {4'h8, mo});
      wr_reg(CCU_IRQ_ADDR, 8'h00);
      a0 = n_adc;
      r0 = n_rst;
      load_timer(m);
      repeat (8) @(posedge clk);
      #1;
      chk(16'(unit_out), 16'(out_of(mo)));
      chk(16'(unit_irq_flag), 16'h0001);
      chk(16'(n_adc - a0), 16'h0001);
      chk(16'(n_rst - r0), 16'(rst_of(mo)));
      wr_reg(CCU_CTRL_ADDR, 8'h00);
      #1;
      chk(16'(unit_out), 16'h0000);
    end
    // a running count leaves equality at once: pending timer reset dropped, no conversion when deselected
    wr_reg(CCU_CFG_ADDR, 8'h00);
    wr_reg(CCU_MLO_ADDR, 8'h34);
    wr_reg(CCU_MHI_ADDR, 8'h12);
    load_timer(16'h0000);
    wr_reg(CCU_CTRL_ADDR, {4'h8, CCU_M_TRIG});
    wr_reg(CCU_IRQ_ADDR, 8'h00);
    a0 = n_adc;
    r0 = n_rst;
    run <= 1'b1;
    load_timer(16'h1234);
    repeat (8) @(posedge clk);
    run <= 1'b0;
    #1;
    chk(16'(unit_irq_flag), 16'h0001);
    chk(16'(n_adc - a0), 16'h0000);
    chk(16'(n_rst - r0), 16'h0000);
    wr_reg(CCU_CTRL_ADDR, 8'h00);
    // capture: every edge kind and prescaler
    foreach (cap_modes[k])
    begin
      mo = cap_modes[k];
      m = 16'(rnd());
      load_timer(m);
      wr_reg(CCU_CTRL_ADDR, 8'h00);
      wr_reg(CCU_CTRL_ADDR, {4'h8, mo});
      wr_reg(CCU_IRQ_ADDR, 8'h00);
      for (int i = 1; i <= div_of(mo); i++)
      begin
        pulse();
        chk(16'(unit_irq_flag), 16'(i == div_of(mo)));
      end
      rd_reg(CCU_MLO_ADDR, lo);
      rd_reg(CCU_MHI_ADDR, hi);
      chk({hi, lo}, m);
    end
    // switching off must drop a part-counted prescale
    wr_reg(CCU_CTRL_ADDR, 8'h86);
    pulse();
    pulse();
    wr_reg(CCU_CTRL_ADDR, 8'h00);
    wr_reg(CCU_CTRL_ADDR, 8'h86);
    wr_reg(CCU_IRQ_ADDR, 8'h00);
    repeat (3) pulse();
    chk(16'(unit_irq_flag), 16'h0000);
    // sleep: timer held, capture only with an external timer clock
    wr_reg(CCU_CTRL_ADDR, 8'h00);
    wr_reg(CCU_CTRL_ADDR, 8'h85);
    wr_reg(CCU_IRQ_ADDR, 8'h02);
    @(posedge clk);
    sleep <= 1'b1;
    run <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk(16'(timer_hold), 16'h0001);
    m = timer_count;
    pulse();
    chk(timer_count, m);
    chk(16'(unit_irq_flag), 16'h0000);
    @(posedge clk);
    timer_ext_clk <= 1'b1;
    pulse();
    chk(16'(unit_irq_flag), 16'h0001);
    chk(16'(wake_req), 16'h0001);
    chk(16'(timer_hold), 16'h0000);
    finish_test();
  end
endmodule : capture_compare_unit_test

// file: tb/ccu_timer_model.sv
// companion timer model: sixteen-bit up counter beside the unit
// assumes the bench may stop, run and preload it on the shared clock
`timescale 1ns/1ns
module ccu_timer_model
(
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // bench control
  input wire logic run,
  input wire logic load,
  input wire logic [15:0] load_val,
  // unit side
  input wire logic timer_reset,
  input wire logic timer_hold,
  output logic [15:0] timer_count
);
  logic [15:0] next_count;

  // counts on clk itself, so it is never an asynchronous counter
  always_comb
  begin
    next_count = timer_count;
    if (load)
      next_count = load_val;
    else if (timer_reset)
      next_count = 16'h0000;
    else if (run && !timer_hold)
      next_count = timer_count + 16'h0001;
  end

  // count register
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      timer_count <= 16'h0000;
    else
      timer_count <= next_count;
  end
endmodule : ccu_timer_model
